/* design/ssc_dev.sv */
// Device end: diagnostic port, two shadow branches, store write and glue
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module ssc_dev (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    ssc_link_if.dev lnk,
    input wire logic ucode_irq_set,
    input wire logic ucode_mem_en,
    input wire logic host_mem_en,
    input wire logic mem_sel_host,
    input wire logic pipe_upd,
    input wire logic [79:0] cs_pipe_in,
    input wire logic [39:0] mac_pipe_in,
    output logic sys_clk_run,
    output logic cs_shift_clk,
    output logic mac_shift_clk,
    output logic shadow_mode,
    output logic shadow_serial_in,
    output logic seq_hold,
    output logic addr_sel_port,
    output logic store_we,
    output logic [15:0] store_addr,
    output logic [63:0] store_data,
    output logic [15:0] map_addr,
    output logic [15:0] map_data,
    output logic mem_en,
    output logic [79:0] cs_pipe,
    output logic [39:0] mac_pipe
);
    import ssc_pkg::*;

    localparam logic [3:0] GAP_LAST = 4'(`SSC_CS_GAP_CYC - 1);

    ssc_state_t state_q;
    ssc_cmd_t cmd_q;
    logic [5:0] bits_q;
    logic [3:0] gap_q;
    logic [31:0] port_pipe_q, port_shd_q, rdata_q;
    logic [79:0] cs_shd_q, cs_pipe_q;
    logic [39:0] mac_shd_q, mac_pipe_q;
    logic cs_drive_q, sys_run_q, done_q, irq_q;
    logic cs_clk_q, mac_clk_q, mode_q, sin_q, hold_q, we_q, mem_en_q;
    logic accept, shift_now, cs_pulse, mac_pulse, mode, force_val, sel_cs, mux_out;
    logic cs_in, mac_in;

    // Clamp a nibble count to the port width
    function automatic logic [5:0] nib_bits(input logic [3:0] n);
        logic [3:0] c;
        c = (n > `SSC_MAX_NIB) ? `SSC_MAX_NIB : n;
        return {c, 2'b00};
    endfunction

    // Command decode and strobes of the current step
    assign accept = (state_q == ST_IDLE) && lnk.cmd_valid;
    assign shift_now = (state_q == ST_SHIFT) && (bits_q != 6'h00);
    assign sel_cs = (cmd_q != SSC_SHIFT_MAC);
    assign mode = (state_q == ST_MODE_ON) || (state_q == ST_MODE_OFF);
    assign force_val = (state_q == ST_MODE_ON);
    assign cs_pulse = (shift_now && sel_cs) || mode;
    assign mac_pulse = shift_now && !sel_cs;

    // Serial-in mux: forced constant under mode, else selected branch end
    assign mux_out = mode ? force_val : (sel_cs ? cs_shd_q[0] : mac_shd_q[0]);
    // Branch inputs: pass-through under mode, else port shadow end
    assign cs_in = mode ? mux_out : port_shd_q[0];
    assign mac_in = mode ? mux_out : port_shd_q[0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= SSC_PORT_WR;
            bits_q <= 6'h00;
            gap_q <= 4'h0;
        end else if (ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (lnk.cmd_valid) begin
                        cmd_q <= lnk.cmd;
                        bits_q <= nib_bits(lnk.nibbles);
                        gap_q <= 4'h0;
                        unique case (lnk.cmd)
                            SSC_PORT_WR: state_q <= ST_PWR;
                            SSC_SHIFT_MAC: state_q <= ST_SHIFT;
                            SSC_SHIFT_CS, SSC_STORE_LOAD: state_q <= ST_PRE;
                            default: state_q <= ST_DONE;
                        endcase
                    end
                end
                ST_PWR: state_q <= ST_DONE;
                ST_PRE: begin
                    gap_q <= gap_q + 4'h1;
                    if (gap_q == GAP_LAST) begin
                        gap_q <= 4'h0;
                        state_q <= (cmd_q == SSC_SHIFT_CS) ? ST_SHIFT : ST_MODE_ON;
                    end
                end
                ST_SHIFT: begin
                    if (bits_q == 6'h00) begin
                        state_q <= sel_cs ? ST_POST : ST_DONE;
                    end else begin
                        bits_q <= bits_q - 6'h01;
                    end
                end
                ST_MODE_ON: state_q <= ST_WRITE;
                ST_WRITE: state_q <= ST_MODE_OFF;
                ST_MODE_OFF: state_q <= ST_POST;
                ST_POST: begin
                    gap_q <= gap_q + 4'h1;
                    if (gap_q == GAP_LAST) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // System clocks stop from acceptance of a store op until the gap ends
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_run_q <= 1'b1;
        end else if (ce) begin
            if (accept && (lnk.cmd == SSC_SHIFT_CS || lnk.cmd == SSC_STORE_LOAD)) begin
                sys_run_q <= 1'b0;
            end else if (state_q == ST_POST && gap_q == GAP_LAST) begin
                sys_run_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Diagnostic port register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_pipe_q <= `SSC_WORD_RST;
            port_shd_q <= `SSC_WORD_RST;
            rdata_q <= `SSC_WORD_RST;
        end else if (ce) begin
            if (accept && lnk.cmd == SSC_PORT_WR) begin
                port_pipe_q <= lnk.wdata;
            end
            if (state_q == ST_PWR || (accept && lnk.cmd == SSC_CAPTURE)) begin
                port_shd_q <= port_pipe_q;
            end else if (shift_now) begin
                port_shd_q <= {mux_out, port_shd_q[31:1]};
            end
            if (accept && lnk.cmd == SSC_PORT_RD) begin
                rdata_q <= port_shd_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Store branch: map port then microcode pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_shd_q <= 80'h0;
            cs_pipe_q <= 80'h0;
            cs_drive_q <= 1'b0;
        end else if (ce) begin
            if (accept && lnk.cmd == SSC_CAPTURE) begin
                cs_shd_q <= cs_pipe_q;
            end else if (cs_pulse && !mode) begin
                cs_shd_q <= {cs_in, cs_shd_q[79:1]};
            end
            if (accept && lnk.cmd == SSC_PIPE_LOAD) begin
                cs_pipe_q <= cs_shd_q;
            end else if (pipe_upd && sys_run_q) begin
                cs_pipe_q <= cs_pipe_in;
            end
            if (cs_pulse && mode) begin
                cs_drive_q <= cs_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Macro branch: opcode, status, interrupt base
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mac_shd_q <= 40'h0;
            mac_pipe_q <= 40'h0;
        end else if (ce) begin
            if (accept && lnk.cmd == SSC_CAPTURE) begin
                mac_shd_q <= mac_pipe_q;
            end else if (mac_pulse) begin
                mac_shd_q <= {mac_in, mac_shd_q[39:1]};
            end
            if (accept && lnk.cmd == SSC_MAC_LOAD) begin
                mac_pipe_q <= mac_shd_q;
            end else if (pipe_upd && sys_run_q) begin
                mac_pipe_q <= mac_pipe_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin images and glue
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_clk_q <= 1'b0;
            mac_clk_q <= 1'b0;
            mode_q <= 1'b0;
            sin_q <= 1'b0;
            hold_q <= 1'b0;
            we_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            cs_clk_q <= cs_pulse;
            mac_clk_q <= mac_pulse;
            mode_q <= mode;
            sin_q <= mux_out;
            hold_q <= (state_q == ST_WRITE);
            we_q <= (state_q == ST_WRITE) && cs_drive_q;
            done_q <= (state_q == ST_DONE);
        end
    end

    // Host interrupt latch: set wins over the clearing port operation
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            if (ucode_irq_set) begin
                irq_q <= 1'b1;
            end else if (accept) begin
                irq_q <= 1'b0;
            end
        end
    end

    // Memory enable source select
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_en_q <= 1'b0;
        end else if (ce) begin
            mem_en_q <= mem_sel_host ? host_mem_en : ucode_mem_en;
        end
    end

    assign sys_clk_run = sys_run_q;
    assign cs_shift_clk = cs_clk_q;
    assign mac_shift_clk = mac_clk_q;
    assign shadow_mode = mode_q;
    assign shadow_serial_in = sin_q;
    assign seq_hold = hold_q;
    assign addr_sel_port = hold_q;
    assign store_we = we_q;
    assign store_addr = cs_pipe_q[79:64];
    assign store_data = cs_shd_q[63:0];
    assign map_addr = mac_pipe_q[39:24];
    assign map_data = cs_shd_q[79:64];
    assign mem_en = mem_en_q;
    assign cs_pipe = cs_pipe_q;
    assign mac_pipe = mac_pipe_q;
    assign lnk.done = done_q;
    assign lnk.rdata = rdata_q;
    assign lnk.irq = irq_q;
endmodule // ssc_dev
`default_nettype wire

/* design/ssc_host.sv */
// Host end: register port that issues diagnostic commands over the link
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module ssc_host (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    ssc_link_if.host lnk,
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import ssc_pkg::*;

    logic busy_q, valid_q, err_q;
    ssc_cmd_t cmd_q;
    logic [3:0] nib_q;
    logic [31:0] wd_q, rd_q, rdata_q;
    ssc_cmd_t new_cmd;
    logic [3:0] new_nib;
    logic is_shift, nib_bad, start, refuse;

    assign new_cmd = ssc_cmd_t'(wdata[`SSC_CMD_LSB +: 3]);
    assign new_nib = wdata[`SSC_NIB_LSB +: 4];
    assign is_shift = (new_cmd == SSC_SHIFT_CS) || (new_cmd == SSC_SHIFT_MAC);
    assign nib_bad = is_shift && ((new_nib == 4'h0) || (new_nib > `SSC_MAX_NIB));
    assign start = wr && addr == `SSC_REG_CMD && !busy_q && !nib_bad;
    assign refuse = wr && addr == `SSC_REG_CMD && (busy_q || nib_bad);

    // ------------------------------------------------------------
    // Command issue; software sequences capture, shifts, reads, loads
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            cmd_q <= SSC_PORT_WR;
            nib_q <= 4'h0;
        end else if (ce) begin
            valid_q <= start;
            if (start) begin
                busy_q <= 1'b1;
                cmd_q <= new_cmd;
                nib_q <= new_nib;
            end else if (lnk.done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Sticky refusal flag, set wins over the write-one clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (ce) begin
            if (refuse) begin
                err_q <= 1'b1;
            end else if (wr && addr == `SSC_REG_STATUS && wdata[`SSC_ST_ERR]) begin
                err_q <= 1'b0;
            end
        end
    end

    // Port data words, outgoing and returned
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wd_q <= `SSC_WORD_RST;
            rd_q <= `SSC_WORD_RST;
        end else if (ce) begin
            if (wr && addr == `SSC_REG_WDATA) begin
                wd_q <= wdata;
            end
            if (lnk.done && cmd_q == SSC_PORT_RD) begin
                rd_q <= lnk.rdata;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= `SSC_WORD_RST;
        end else if (ce) begin
            if (rd) begin
                unique case (addr)
                    `SSC_REG_CMD: rdata_q <= {24'h0, nib_q, 1'b0, cmd_q};
                    `SSC_REG_WDATA: rdata_q <= wd_q;
                    `SSC_REG_STATUS: rdata_q <= {29'h0, err_q, lnk.irq, busy_q};
                    `SSC_REG_RDATA: rdata_q <= rd_q;
                endcase
            end else begin
                rdata_q <= `SSC_WORD_RST;
            end
        end
    end

    assign rdata = rdata_q;
    assign lnk.cmd_valid = valid_q;
    assign lnk.cmd = cmd_q;
    assign lnk.nibbles = nib_q;
    assign lnk.wdata = wd_q;
endmodule // ssc_host
`default_nettype wire

/* design/ssc_link_if.sv */
// Command link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
    logic cmd_valid;
    ssc_pkg::ssc_cmd_t cmd;
    logic [3:0] nibbles;
    logic [31:0] wdata;
    logic done;
    logic [31:0] rdata;
    logic irq;
    modport dev (input cmd_valid, cmd, nibbles, wdata, output done, rdata, irq);
    modport host (output cmd_valid, cmd, nibbles, wdata, input done, rdata, irq);
endinterface
`default_nettype wire

/* design/ssc_map.svh */
// Constants of the shadow scan chain control: widths, timing, register map
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_PORT_W 32
`define SSC_NIB_W 4
`define SSC_MAX_NIB 4'h8
`define SSC_BIT_CNT_W 6
`define SSC_MAP_W 16
`define SSC_UPIPE_W 64
`define SSC_CS_W 80
`define SSC_OPC_W 16
`define SSC_MAC_W 40
`define SSC_OPC_LSB 24
`define SSC_CLK_NS 8
`define SSC_CS_GAP_NS 65
`define SSC_CS_GAP_CYC ((`SSC_CS_GAP_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_GAP_CNT_W 4
`define SSC_ADDR_W 2
`define SSC_REG_CMD 2'h0
`define SSC_REG_WDATA 2'h1
`define SSC_REG_STATUS 2'h2
`define SSC_REG_RDATA 2'h3
`define SSC_CMD_LSB 0
`define SSC_NIB_LSB 4
`define SSC_ST_BUSY 0
`define SSC_ST_IRQ 1
`define SSC_ST_ERR 2
`define SSC_WORD_RST 32'h0000_0000
`endif

/* design/ssc_pkg.sv */
// Types shared by both ends of the shadow scan chain control
package ssc_pkg;
    typedef enum logic [2:0] {
        SSC_PORT_WR, SSC_PORT_RD, SSC_CAPTURE, SSC_PIPE_LOAD,
        SSC_MAC_LOAD, SSC_STORE_LOAD, SSC_SHIFT_CS, SSC_SHIFT_MAC
    } ssc_cmd_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PWR, ST_PRE, ST_SHIFT, ST_MODE_ON, ST_WRITE, ST_MODE_OFF, ST_POST, ST_DONE
    } ssc_state_t;
endpackage

/* test/ssc_link_properties.sv */
// Timing and handshake checks on the command link
`timescale 1ns/1ps
`default_nettype none
module ssc_link_properties (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire ssc_pkg::ssc_cmd_t cmd,
    input wire logic [3:0] nibbles,
    input wire logic [31:0] wdata,
    input wire logic done,
    input wire logic [31:0] rdata,
    input wire logic irq
);
    import ssc_pkg::*;
    logic pend_q;
    logic [6:0] cnt_q;
    logic [3:0] nib_q;
    ssc_cmd_t cmd_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ----
    // Command in flight and its age in cycles
    // ----
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_q <= 1'b0;
            cnt_q <= 7'h0;
        end else if (cmd_valid) begin
            pend_q <= 1'b1;
            cnt_q <= 7'h1;
        end else if (done) begin
            pend_q <= 1'b0;
        end else if (pend_q) begin
            cnt_q <= cnt_q + 7'h1;
        end
    end
    // Kind and nibble count of the command in flight
    always_ff @(posedge clk_sys) begin
        if (cmd_valid) begin
            cmd_q <= cmd;
            nib_q <= nibbles;
        end
    end
    // ----
    // Properties
    // ----
    property p_short_done;
        cmd_valid && cmd inside {SSC_PORT_RD, SSC_CAPTURE, SSC_PIPE_LOAD, SSC_MAC_LOAD} |=> !done ##1 done;
    endproperty
    a_short_done: assert property (p_short_done) else $error("short command done off time");
    property p_wr_done;
        cmd_valid && cmd == SSC_PORT_WR |=> !done [*2] ##1 done;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("port write done off time");
    property p_mac_len;
        done && pend_q && cmd_q == SSC_SHIFT_MAC |-> cnt_q inside {[{1'b0, nib_q, 2'b00} + 7'h2 : {1'b0, nib_q, 2'b00} + 7'h3]};
    endproperty
    a_mac_len: assert property (p_mac_len) else $error("opcode shift length wrong");
    property p_cs_len;
        done && pend_q && cmd_q == SSC_SHIFT_CS |-> cnt_q == {1'b0, nib_q, 2'b00} + 7'h15;
    endproperty
    a_cs_len: assert property (p_cs_len) else $error("store shift lacks clock gaps");
    property p_store_len;
        done && pend_q && cmd_q == SSC_STORE_LOAD |-> cnt_q inside {[7'h16 : 7'h17]};
    endproperty
    a_store_len: assert property (p_store_len) else $error("store load length wrong");
    property p_done_pulse;
        done |-> pend_q ##1 !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("stray or long done");
    property p_one_flight;
        cmd_valid |-> !pend_q ##1 !cmd_valid;
    endproperty
    a_one_flight: assert property (p_one_flight) else $error("second command in flight");
    property p_nib_legal;
        cmd_valid && cmd inside {SSC_SHIFT_CS, SSC_SHIFT_MAC} |-> nibbles inside {[4'h1 : 4'h8]};
    endproperty
    a_nib_legal: assert property (p_nib_legal) else $error("shift over port width");
    property p_rdata_hold;
        $changed(rdata) |-> pend_q && cmd_q == SSC_PORT_RD;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read word moved without read");
    property p_irq_clear;
        $fell(irq) |-> $past(cmd_valid);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt cleared without port operation");
endmodule // ssc_link_properties
`default_nettype wire

/* test/tb.sv */
// Self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module tb;
    import ssc_pkg::*;
    logic clk_sys, rst, ce, wr, rd, rd_seen, ucode_irq_set, ucode_mem_en, host_mem_en, mem_sel_host, pipe_upd;
    logic sys_clk_run, cs_shift_clk, mac_shift_clk, shadow_mode, shadow_serial_in, seq_hold, addr_sel_port;
    logic store_we, mem_en;
    logic [1:0] addr;
    logic [31:0] wdata, rdata, p_m, pw, e_v, m_v;
    logic [15:0] store_addr, map_addr, map_data;
    logic [63:0] store_data;
    logic [79:0] cs_pipe_in, cs_pipe, cs_m, cs_pl;
    logic [39:0] mac_pipe_in, mac_pipe, mac_m, mac_pl;
    logic [31:0] exp_q[$], msk_q[$];
    int err_count, check_count, n_cs, n_mac, n_set, n_we, k, n;
    ssc_link_if u_ssc_link_if();
    ssc_host u_ssc_host (.clk_sys, .rst, .ce, .lnk(u_ssc_link_if.host), .addr, .wdata, .wr, .rd, .rdata);
    ssc_dev u_ssc_dev (.clk_sys, .rst, .ce, .lnk(u_ssc_link_if.dev), .ucode_irq_set, .ucode_mem_en, .host_mem_en,
        .mem_sel_host, .pipe_upd, .cs_pipe_in, .mac_pipe_in, .sys_clk_run, .cs_shift_clk, .mac_shift_clk,
        .shadow_mode, .shadow_serial_in, .seq_hold, .addr_sel_port, .store_we, .store_addr, .store_data,
        .map_addr, .map_data, .mem_en, .cs_pipe, .mac_pipe);
    ssc_link_properties u_props (.clk_sys, .rst, .cmd_valid(u_ssc_link_if.cmd_valid), .cmd(u_ssc_link_if.cmd),
        .nibbles(u_ssc_link_if.nibbles), .wdata(u_ssc_link_if.wdata), .done(u_ssc_link_if.done),
        .rdata(u_ssc_link_if.rdata), .irq(u_ssc_link_if.irq));
    // ----
    // Clock, checks and bus tasks
    // ----
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask
    // Closed loop of port and branch: port bit 0 leaves first, branch bit 0 enters port top
    task automatic mdl(input bit cs, input int n);
        logic [111:0] v;
        logic b;
        int w;
        w = cs ? 112 : 72;
        v = cs ? {p_m, cs_m} : {40'h0, p_m, mac_m};
        repeat (4 * n) begin
            b = v[0];
            v = v >> 1;
            v[w - 1] = b;
        end
        if (cs) {p_m, cs_m} = v;
        else {p_m, mac_m} = v[71:0];
    endtask
    task automatic run_cmd(input ssc_cmd_t c, input int n);
        int i;
        wr_reg(`SSC_REG_CMD, {24'h0, n[3:0], 1'b0, c});
        {n_cs, n_mac, n_set, n_we} = '0;
        for (i = 0; i < 99 && u_ssc_link_if.done !== 1'b1; i++) @(negedge clk_sys);
        if (i == 99) begin
            err_count++;
            $display("Error %0t: no done", $time);
            results();
        end
        chk(sys_clk_run === 1'b1, "system clocks left halted");
        if (c == SSC_SHIFT_CS || c == SSC_SHIFT_MAC) begin
            chk(n_cs == (c == SSC_SHIFT_CS ? 4 * n : 0) && n_mac == (c == SSC_SHIFT_MAC ? 4 * n : 0), "pulses");
            mdl(c == SSC_SHIFT_CS, n);
        end
    endtask
    task automatic port_wr(input logic [31:0] d);
        wr_reg(`SSC_REG_WDATA, d);
        run_cmd(SSC_PORT_WR, 0);
        pw = d;
        p_m = d;
    endtask
    task automatic port_rd;
        run_cmd(SSC_PORT_RD, 0);
        rd_reg(`SSC_REG_RDATA, p_m, 32'hffff_ffff);
    endtask
    // Read results appear one cycle after the strobe
    always @(posedge clk_sys) rd_seen <= rd;
    // Device pins and read data watched off the clock edge
    always @(negedge clk_sys) begin
        if (cs_shift_clk === 1'b1) begin
            n_cs++;
            chk(sys_clk_run === 1'b0, "clocks run in store shift");
            if ((shadow_mode & shadow_serial_in) === 1'b1) n_set++;
        end
        if (mac_shift_clk === 1'b1) begin
            n_mac++;
            chk(shadow_mode === 1'b0, "opcode branch clocked in mode");
        end
        if (store_we === 1'b1) begin
            n_we++;
            chk(store_data === cs_m[63:0] && map_data === cs_m[79:64] && store_addr === cs_pl[79:64]
                && map_addr === mac_pl[39:24] && seq_hold && addr_sel_port, "store write");
        end
        if (rd_seen === 1'b1) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            chk((rdata & m_v) === (e_v & m_v), "read data");
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        {wr, rd, ucode_irq_set, ucode_mem_en, host_mem_en, mem_sel_host, pipe_upd} = '0;
        {addr, wdata, cs_pipe_in, mac_pipe_in} = '0;
        {rst, ce} = 2'h3;
        void'($urandom(32'h2383));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(`SSC_REG_STATUS, 32'h0, 32'hffff_ffff);
        rd_reg(`SSC_REG_RDATA, 32'h0, 32'hffff_ffff);
        $display("reset test done");
        port_wr($urandom);
        @(posedge clk_sys);
        cs_pipe_in <= {16'($urandom), $urandom, $urandom};
        mac_pipe_in <= {8'($urandom), $urandom};
        pipe_upd <= 1'b1;
        @(posedge clk_sys);
        pipe_upd <= 1'b0;
        // Shadows still hold their reset value, pipelines hold the new words
        {cs_m, cs_pl, mac_m, mac_pl} = {80'h0, cs_pipe_in, 40'h0, mac_pipe_in};
        run_cmd(SSC_SHIFT_MAC, 8);
        run_cmd(SSC_CAPTURE, 0);
        p_m = pw;
        {cs_m, mac_m} = {cs_pl, mac_pl};
        port_rd();
        for (k = 0; k < 24; k++) begin
            n = k < 2 ? 1 + 7 * k : 1 + $urandom % 8;
            if ($urandom % 4 == 0) port_wr($urandom);
            run_cmd($urandom % 2 ? SSC_SHIFT_CS : SSC_SHIFT_MAC, n);
            port_rd();
        end
        $display("loop test done");
        run_cmd(SSC_PIPE_LOAD, 0);
        cs_pl = cs_m;
        run_cmd(SSC_MAC_LOAD, 0);
        mac_pl = mac_m;
        run_cmd(SSC_STORE_LOAD, 0);
        chk(n_we == 1 && n_set == 1 && n_cs == 2 && n_mac == 0, "store sequence");
        chk(cs_pipe === cs_pl && mac_pipe === mac_pl, "pipeline load");
        $display("load test done");
        @(posedge clk_sys);
        ucode_irq_set <= 1'b1;
        @(posedge clk_sys);
        ucode_irq_set <= 1'b0;
        rd_reg(`SSC_REG_STATUS, 32'h2, 32'h2);
        port_rd();
        rd_reg(`SSC_REG_STATUS, 32'h0, 32'h2);
        // Set and clear in one cycle: the set wins
        ucode_irq_set <= 1'b1;
        port_rd();
        ucode_irq_set <= 1'b0;
        rd_reg(`SSC_REG_STATUS, 32'h2, 32'h2);
        $display("interrupt test done");
        for (k = 0; k < 16; k += 9) wr_reg(`SSC_REG_CMD, {24'h0, 4'(k), 1'b0, SSC_SHIFT_MAC});
        rd_reg(`SSC_REG_STATUS, 32'h4, 32'h5);
        wr_reg(`SSC_REG_STATUS, 32'h4);
        rd_reg(`SSC_REG_STATUS, 32'h0, 32'h4);
        wr_reg(`SSC_REG_CMD, {24'h0, 4'h1, 1'b0, SSC_SHIFT_MAC});
        run_cmd(SSC_PORT_WR, 0);
        mdl(1'b0, 1);
        rd_reg(`SSC_REG_STATUS, 32'h4, 32'h4);
        rd_reg(`SSC_REG_CMD, {24'h0, 4'h1, 1'b0, SSC_SHIFT_MAC}, 32'hffff_ffff);
        rd_reg(`SSC_REG_WDATA, pw, 32'hffff_ffff);
        port_rd();
        $display("refusal test done");
        for (k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            {mem_sel_host, host_mem_en, ucode_mem_en} <= k[2:0];
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk(mem_en === (mem_sel_host ? host_mem_en : ucode_mem_en), "memory enable");
        end
        // Clock enable low freezes the registered select, high lets it follow
        @(posedge clk_sys);
        {ce, mem_sel_host, ucode_mem_en} <= 3'h0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(mem_en === 1'b1, "state moved with clock enable low");
        @(posedge clk_sys);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(mem_en === 1'b0, "state frozen after clock enable high");
        $display("memory enable test done");
        results();
    end
endmodule // tb
`default_nettype wire
